// file: hw/qdh_pkg.sv
package qdh_pkg;

    // widths
    localparam int QDH_BUS_W     = 16;
    localparam int QDH_CHAN_W    = 12;
    localparam int QDH_NUM_CHAN  = 4;
    localparam int QDH_SEL_W     = 2;
    localparam int QDH_SW_W      = 9;
    localparam int QDH_DIGOUT_W  = 4;
    localparam int QDH_LO_BYTE_W = 8;
    localparam int QDH_PAD_W     = QDH_BUS_W - QDH_CHAN_W;

    // address field positions
    localparam int QDH_MATCH_LSB = 3;
    localparam int QDH_MATCH_MSB = QDH_MATCH_LSB + QDH_SW_W - 1;
    localparam int QDH_SEL_LSB   = 1;
    localparam int QDH_SEL_MSB   = QDH_SEL_LSB + QDH_SEL_W - 1;
    localparam int QDH_BYTE_BIT  = 0;

    // values
    localparam logic [QDH_CHAN_W-1:0] QDH_CHAN_RST    = 12'h000;
    localparam logic [QDH_PAD_W-1:0]  QDH_RD_PAD      = 4'h0;
    localparam logic [QDH_SEL_W-1:0]  QDH_DIGOUT_CHAN = 2'h3;

    typedef logic [QDH_CHAN_W-1:0]                    qdh_chan_t;
    typedef logic [QDH_NUM_CHAN-1:0][QDH_CHAN_W-1:0]  qdh_chans_t;

    typedef enum logic [1:0] {
        QDH_ST_IDLE   = 2'b00,
        QDH_ST_IGNORE = 2'b01,
        QDH_ST_SEL    = 2'b10,
        QDH_ST_REPLY  = 2'b11
    } qdh_fsm_t;

    // bus and strap pins after synchronisation
    typedef struct packed {
        logic [QDH_BUS_W-1:0] addr_data;
        logic                 io_page;
        logic                 sync;
        logic                 din;
        logic                 dout;
        logic                 byte_sel;
        logic [QDH_SW_W-1:0]  switches;
    } qdh_pins_t;

    typedef struct packed {
        qdh_pins_t meta;
        qdh_pins_t stable;
    } qdh_sync_st_t;

    // write strobe bundle for one holding register
    typedef struct packed {
        logic                 wr_lo;
        logic                 wr_hi;
        logic [QDH_BUS_W-1:0] wdata;
    } qdh_wr_t;

    typedef struct packed {
        qdh_chan_t value;
    } qdh_hold_st_t;

    typedef struct packed {
        qdh_fsm_t             fsm;
        logic                 sync_prev;
        logic [QDH_SEL_W-1:0] sel;
        logic                 hi_byte;
        logic                 reply;
        logic                 oe_n;
        logic [QDH_BUS_W-1:0] rdata;
    } qdh_bus_st_t;

    localparam qdh_bus_st_t QDH_BUS_RST = '{
        fsm:       QDH_ST_IDLE,
        sync_prev: 1'b0,
        sel:       '0,
        hi_byte:   1'b0,
        reply:     1'b0,
        oe_n:      1'b1,
        rdata:     '0
    };

endpackage

// file: hw/qdh_sync.sv
`timescale 1ns/1ps
`default_nettype none
module qdh_sync (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // pins in, stable copy out
    input  wire qdh_pkg::qdh_pins_t pins_async,
    output var  qdh_pkg::qdh_pins_t pins_sync
);
    import qdh_pkg::*;

    qdh_sync_st_t s_q;
    qdh_sync_st_t s_d;

    always_comb begin
        s_d        = s_q;
        s_d.meta   = pins_async;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_sync = s_q.stable;

endmodule
`default_nettype wire

// file: hw/qdh_holding_reg.sv
`timescale 1ns/1ps
`default_nettype none
module qdh_holding_reg (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // write strobes
    input  wire qdh_pkg::qdh_wr_t wr,
    // stored value
    output var  qdh_pkg::qdh_chan_t value
);
    import qdh_pkg::*;

    qdh_hold_st_t s_q;
    qdh_hold_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr.wr_lo) begin
            s_d.value[QDH_LO_BYTE_W-1:0] = wr.wdata[QDH_LO_BYTE_W-1:0];
        end
        if (wr.wr_hi) begin
            s_d.value[QDH_CHAN_W-1:QDH_LO_BYTE_W] = wr.wdata[QDH_CHAN_W-1:QDH_LO_BYTE_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '{value: QDH_CHAN_RST};
        end else begin
            s_q <= s_d;
        end
    end

    // single buffered: the stored value is the converter input
    assign value = s_q.value;

    AST_HOLD_KEEPS: assert property (@(posedge clk_sys) disable iff (srst)
        !wr.wr_lo && !wr.wr_hi |=> $stable(value))
        else $error("holding value changed without a write");

endmodule
`default_nettype wire

// file: hw/qdh_top.sv
// Overview of operation
// - four holding registers, word or byte access
// - each register stores a 12-bit code
// - writes reach converter directly, single buffered
// - no control or status register
// - converter inputs follow latest written value
// - writes update register, reads drive data
// - respond only on switch address match
// - channel 3 bits 0-3 drive output port
// - channel 3 serves 12-bit or 8+4 use
// - reset clears registers, values then held
// - match bits 3-11 with page select, decode bits 1-2
// - offset binary codes pass unchanged
`timescale 1ns/1ps
`default_nettype none
module qdh_top (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    // multiplexed address and data lines
    input  wire logic [15:0]              bus_data_address_lines_i,
    output var  logic [15:0]              bus_data_address_lines_o,
    output var  logic                     bus_data_address_lines_oe_n,
    // bus control
    input  wire logic                     io_page_select,
    input  wire logic                     bus_sync,
    input  wire logic                     bus_din,
    input  wire logic                     bus_dout,
    input  wire logic                     bus_byte,
    output var  logic                     bus_reply,
    // address strap
    input  wire logic [8:0]               address_switch_pack,
    // converter and discrete outputs
    output var  qdh_pkg::qdh_chans_t      channel_value,
    output var  logic [3:0]               discrete_out
);
    import qdh_pkg::*;

    qdh_pins_t   pins_a;
    qdh_pins_t   p;
    qdh_bus_st_t s_q;
    qdh_bus_st_t s_d;
    qdh_wr_t     wr;
    qdh_wr_t     wr_ch [QDH_NUM_CHAN];
    qdh_chans_t  chans;
    logic        sync_rise;
    logic        addr_match;
    logic        rd_take;
    logic        wr_take;

    // gather pins
    always_comb begin
        pins_a          = '0;
        pins_a.addr_data = bus_data_address_lines_i;
        pins_a.io_page  = io_page_select;
        pins_a.sync     = bus_sync;
        pins_a.din      = bus_din;
        pins_a.dout     = bus_dout;
        pins_a.byte_sel = bus_byte;
        pins_a.switches = address_switch_pack;
    end

    qdh_sync u_sync (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .pins_async (pins_a),
        .pins_sync  (p)
    );

    // address phase decode
    assign sync_rise  = p.sync && !s_q.sync_prev;
    assign addr_match = p.io_page
                        && (p.addr_data[QDH_MATCH_MSB:QDH_MATCH_LSB] == p.switches);
    assign rd_take    = (s_q.fsm == QDH_ST_SEL) && p.din;
    assign wr_take    = (s_q.fsm == QDH_ST_SEL) && p.dout && !p.din;

    always_comb begin
        s_d           = s_q;
        wr            = '0;
        s_d.sync_prev = p.sync;
        case (s_q.fsm)
            QDH_ST_IDLE: begin
                if (sync_rise) begin
                    s_d.sel     = p.addr_data[QDH_SEL_MSB:QDH_SEL_LSB];
                    s_d.hi_byte = p.addr_data[QDH_BYTE_BIT];
                    if (addr_match) begin
                        s_d.fsm = QDH_ST_SEL;
                    end else begin
                        s_d.fsm = QDH_ST_IGNORE;
                    end
                end
            end
            QDH_ST_IGNORE: begin
                s_d.fsm = QDH_ST_IGNORE;
            end
            QDH_ST_SEL: begin
                if (rd_take) begin
                    // only the four holding registers exist
                    s_d.rdata = {QDH_RD_PAD, chans[s_q.sel]};
                    s_d.oe_n  = 1'b0;
                    s_d.reply = 1'b1;
                    s_d.fsm   = QDH_ST_REPLY;
                end else if (wr_take) begin
                    wr.wr_lo  = !p.byte_sel || !s_q.hi_byte;
                    wr.wr_hi  = !p.byte_sel || s_q.hi_byte;
                    wr.wdata  = p.addr_data;
                    s_d.reply = 1'b1;
                    s_d.fsm   = QDH_ST_REPLY;
                end
            end
            QDH_ST_REPLY: begin
                if (!p.din && !p.dout) begin
                    s_d.reply = 1'b0;
                    s_d.oe_n  = 1'b1;
                    s_d.fsm   = QDH_ST_SEL;
                end
            end
            default: begin
                s_d.fsm = QDH_ST_IDLE;
            end
        endcase
        // end of the bus cycle releases everything
        if (!p.sync) begin
            s_d.fsm   = QDH_ST_IDLE;
            s_d.reply = 1'b0;
            s_d.oe_n  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= QDH_BUS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // route the strobes to the addressed register
    always_comb begin
        for (int i = 0; i < QDH_NUM_CHAN; i++) begin
            wr_ch[i] = wr;
            if (s_q.sel != QDH_SEL_W'(i)) begin
                wr_ch[i].wr_lo = 1'b0;
                wr_ch[i].wr_hi = 1'b0;
            end
        end
    end

    for (genvar g = 0; g < QDH_NUM_CHAN; g++) begin : g_chan
        qdh_holding_reg u_hold (
            .clk_sys (clk_sys),
            .srst    (srst),
            .wr      (wr_ch[g]),
            .value   (chans[g])
        );
    end

    assign channel_value               = chans;
    assign discrete_out                = chans[QDH_DIGOUT_CHAN][QDH_DIGOUT_W-1:0];
    assign bus_data_address_lines_o    = s_q.rdata;
    assign bus_data_address_lines_oe_n = s_q.oe_n;
    assign bus_reply                   = s_q.reply;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    AST_REPLY_NEEDS_MATCH: assert property (
        bus_reply |-> (s_q.fsm == QDH_ST_REPLY))
        else $error("reply given outside a selected cycle");

    AST_IGNORE_SILENT: assert property (
        (s_q.fsm == QDH_ST_IGNORE) |-> !bus_reply && bus_data_address_lines_oe_n)
        else $error("device answered an unmatched address");

    AST_MATCH_SELECTS: assert property (
        (s_q.fsm == QDH_ST_IDLE) && sync_rise |=>
            (s_q.fsm == ($past(addr_match) ? QDH_ST_SEL : QDH_ST_IGNORE))
            || !p.sync)
        else $error("address match decision wrong");

    AST_WORD_WRITE: assert property (
        wr_take && !p.byte_sel |=>
            chans[$past(s_q.sel)] == $past(p.addr_data[QDH_CHAN_W-1:0]))
        else $error("word write not reflected on channel");

    AST_BYTE_LO_KEEPS_HI: assert property (
        wr_take && p.byte_sel && !s_q.hi_byte |=>
            chans[$past(s_q.sel)][QDH_CHAN_W-1:QDH_LO_BYTE_W]
                == $past(chans[s_q.sel][QDH_CHAN_W-1:QDH_LO_BYTE_W])
            && chans[$past(s_q.sel)][QDH_LO_BYTE_W-1:0]
                == $past(p.addr_data[QDH_LO_BYTE_W-1:0]))
        else $error("low byte write disturbed the high byte");

    AST_OTHER_CHAN_HELD: assert property (
        wr_take |=> chans[$past(s_q.sel) + 2'h1] == $past(chans[s_q.sel + 2'h1]))
        else $error("write leaked into another channel");

    AST_READ_DATA: assert property (
        rd_take |=> !bus_data_address_lines_oe_n && bus_reply
            && bus_data_address_lines_o == {QDH_RD_PAD, chans[s_q.sel]})
        else $error("read did not return the holding register");

    AST_DIGOUT_FOLLOWS: assert property (
        wr_take && (s_q.sel == QDH_DIGOUT_CHAN) && !p.byte_sel |=>
            discrete_out == $past(p.addr_data[QDH_DIGOUT_W-1:0]))
        else $error("discrete output not updated by channel 3 write");

    AST_RESET_CLEARS: assert property (
        $past(srst) |-> chans == '0 && !bus_reply && bus_data_address_lines_oe_n)
        else $error("registers not cleared by reset");

    AST_REPLY_RELEASE: assert property (
        (s_q.fsm == QDH_ST_REPLY) && !p.din && !p.dout |=>
            !bus_reply ##1 !bus_reply || (s_q.fsm == QDH_ST_REPLY))
        else $error("reply not released after strobes dropped");

    AST_BYTE_HI_KEEPS_LO: assert property (
        wr_take && p.byte_sel && s_q.hi_byte |=>
            chans[$past(s_q.sel)][QDH_LO_BYTE_W-1:0]
                == $past(chans[s_q.sel][QDH_LO_BYTE_W-1:0])
            && chans[$past(s_q.sel)][QDH_CHAN_W-1:QDH_LO_BYTE_W]
                == $past(p.addr_data[QDH_CHAN_W-1:QDH_LO_BYTE_W]))
        else $error("high byte write disturbed the low byte");

    AST_OTHER_CHAN_HELD_2: assert property (
        wr_take |=>
            chans[$past(s_q.sel) + 2'h2] == $past(chans[s_q.sel + 2'h2]))
        else $error("write leaked into the channel two above");

    AST_OTHER_CHAN_HELD_3: assert property (
        wr_take |=>
            chans[$past(s_q.sel) + 2'h3] == $past(chans[s_q.sel + 2'h3]))
        else $error("write leaked into the channel three above");

    AST_READ_PAD_ZERO: assert property (
        !bus_data_address_lines_oe_n |->
            bus_data_address_lines_o[QDH_BUS_W-1:QDH_CHAN_W] == QDH_RD_PAD)
        else $error("bits above the stored value read as nonzero");

    AST_DRIVE_WITH_REPLY: assert property (
        !bus_data_address_lines_oe_n |->
            bus_reply)
        else $error("data lines driven without a reply");

    AST_SYNC_LOW_RELEASES: assert property (
        !p.sync |=>
            !bus_reply
            && bus_data_address_lines_oe_n
            && (s_q.fsm == QDH_ST_IDLE))
        else $error("end of bus cycle did not release the device");

    AST_IDLE_SILENT: assert property (
        (s_q.fsm == QDH_ST_IDLE) |->
            !bus_reply && bus_data_address_lines_oe_n)
        else $error("device answered while idle");

    AST_UNSELECTED_NO_WRITE: assert property (
        (s_q.fsm != QDH_ST_SEL) |=>
            $stable(chans))
        else $error("holding register written outside a selected cycle");

    AST_NO_PAGE_IGNORED: assert property (
        (s_q.fsm == QDH_ST_IDLE) && sync_rise && !p.io_page |=>
            (s_q.fsm != QDH_ST_SEL))
        else $error("address selected without page select");

    AST_SEL_LATCHED: assert property (
        (s_q.fsm == QDH_ST_IDLE) && sync_rise |=>
            s_q.sel == $past(p.addr_data[QDH_SEL_MSB:QDH_SEL_LSB]))
        else $error("register select not taken from address bits");

    AST_READ_KEEPS_CHANS: assert property (
        rd_take |=>
            $stable(chans))
        else $error("read cycle changed a holding register");

    AST_REPLY_FROM_STROBE: assert property (
        $rose(bus_reply) |->
            $past(rd_take || wr_take))
        else $error("reply raised without a data strobe");

    AST_REPLY_HOLDS: assert property (
        (s_q.fsm == QDH_ST_REPLY) && p.sync && (p.din || p.dout) |=>
            bus_reply)
        else $error("reply dropped while the strobe stands");

    AST_RDATA_STANDS: assert property (
        !bus_data_address_lines_oe_n |=>
            bus_data_address_lines_oe_n || $stable(bus_data_address_lines_o))
        else $error("read data changed while driven");

    AST_CHANGE_NEEDS_WRITE: assert property (
        !$stable(chans) |->
            $past(wr_take))
        else $error("holding register changed without a write strobe");

    AST_DISCRETE_HI_BYTE_KEEPS: assert property (
        wr_take && (s_q.sel == QDH_DIGOUT_CHAN) && p.byte_sel && s_q.hi_byte |=>
            $stable(discrete_out))
        else $error("high byte write moved the discrete outputs");

    COV_WORD_WRITE: cover property (wr_take && !p.byte_sel ##1 bus_reply);
    COV_BYTE_WRITE: cover property (wr_take && p.byte_sel && s_q.hi_byte);
    COV_READ:       cover property (rd_take ##1 !bus_data_address_lines_oe_n);
    COV_IGNORED:    cover property ((s_q.fsm == QDH_ST_IGNORE) ##1 !p.sync);
    COV_READ_WRITE: cover property (rd_take ##[1:20] wr_take);

endmodule
`default_nettype wire

// file: tb/qdh_proc_model.sv
`timescale 1ns/1ps
`default_nettype none
module qdh_proc_model (
    // clock
    input  wire logic        clk_sys,
    // bus drive
    output var  logic [15:0] lines,
    output var  logic        page,
    output var  logic        sync,
    output var  logic        din,
    output var  logic        dout,
    output var  logic        bsel,
    // device answer
    input  wire logic [15:0] lines_rd,
    input  wire logic        reply
);
    initial begin
        {lines, page, sync, din, dout, bsel} = '0;
    end

    // bounded wait, a refused cycle simply runs out
    task automatic wait_reply(input logic lvl);
        for (int i = 0; i < 20 && reply !== lvl; i++) @(posedge clk_sys);
    endtask

    // address held four edges so the synced copy is latched
    task automatic addr_phase(input logic [15:0] a, input logic pg);
        @(posedge clk_sys);
        lines <= a;
        page <= pg;
        sync <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic end_cycle(input logic [15:0] last);
        wait_reply(1'b0);
        lines <= ~last;
        sync <= 1'b0;
        page <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b, input logic pg);
        addr_phase(a, pg);
        lines <= d;
        bsel <= b;
        dout <= 1'b1;
        wait_reply(1'b1);
        dout <= 1'b0;
        bsel <= 1'b0;
        end_cycle(d);
    endtask

    // released lines show the inverse of the address
    task automatic rd(input logic [15:0] a, input logic pg, output logic [15:0] d);
        addr_phase(a, pg);
        lines <= ~a;
        din <= 1'b1;
        wait_reply(1'b1);
        d = lines_rd;
        din <= 1'b0;
        end_cycle(~a);
    endtask
endmodule
`default_nettype wire

// file: tb/test_quad_dac_holding_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_quad_dac_holding_registers;
    import qdh_pkg::*;
    localparam logic [8:0]  SW   = 9'h024;
    localparam logic [15:0] BASE = 16'hF120;
    localparam logic [47:0] VALS = 48'hA5C_001_FFF_800;
    logic        clk_sys = 1'b0;
    logic        srst;
    logic [8:0]  sw;
    logic [15:0] lines_i;
    logic [15:0] lines_o;
    logic [15:0] rv;
    logic        oe_n, page, sync, din, dout, bsel, reply;
    qdh_chans_t  chans;
    logic [3:0]  dig;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n_ans = 0;

    always #10 clk_sys = ~clk_sys;

    qdh_top dut_u (
        .clk_sys(clk_sys), .srst(srst),
        .bus_data_address_lines_i(lines_i), .bus_data_address_lines_o(lines_o),
        .bus_data_address_lines_oe_n(oe_n), .io_page_select(page),
        .bus_sync(sync), .bus_din(din), .bus_dout(dout), .bus_byte(bsel),
        .bus_reply(reply), .address_switch_pack(sw),
        .channel_value(chans), .discrete_out(dig)
    );

    qdh_proc_model proc_u (
        .clk_sys(clk_sys), .lines(lines_i), .page(page), .sync(sync),
        .din(din), .dout(dout), .bsel(bsel), .lines_rd(lines_o), .reply(reply)
    );

    // counts every cycle the device answers or drives
    always @(posedge clk_sys) begin
        cyc++;
        if (reply === 1'b1 || oe_n === 1'b0) n_ans++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic all_zero;
        for (int i = 0; i < 4; i++) chk("chan", {4'h0, chans[i]}, 16'h0000);
        chk("dig", {12'h000, dig}, 16'h0000);
        chk("idle", {14'h0, reply, oe_n}, 16'h0001);
    endtask

    task automatic t_word;
        for (int i = 0; i < 4; i++) begin
            proc_u.wr(BASE + 16'(2 * i), {4'hF, VALS[i*12 +: 12]}, 1'b0, 1'b1);
            chk("chan", {4'h0, chans[i]}, {4'h0, VALS[i*12 +: 12]});
            proc_u.rd(BASE + 16'(2 * i), 1'b1, rv);
            chk("read", rv, {4'h0, VALS[i*12 +: 12]});
        end
        for (int i = 0; i < 4; i++) chk("kept", {4'h0, chans[i]}, {4'h0, VALS[i*12 +: 12]});
        chk("dig", {12'h000, dig}, 16'h000C);
    endtask

    task automatic t_byte;
        proc_u.wr(BASE + 16'h0006, 16'hFF3C, 1'b1, 1'b1);
        chk("lo byte", {4'h0, chans[3]}, 16'h0A3C);
        proc_u.wr(BASE + 16'h0007, 16'hF6FF, 1'b1, 1'b1);
        chk("hi byte", {4'h0, chans[3]}, 16'h063C);
        chk("dig", {12'h000, dig}, 16'h000C);
        proc_u.rd(BASE + 16'h0006, 1'b1, rv);
        chk("read", rv, 16'h063C);
    endtask

    task automatic t_refuse;
        int n0;
        n0 = n_ans;
        proc_u.wr(BASE ^ 16'h0008, 16'h0123, 1'b0, 1'b1);
        proc_u.wr(BASE, 16'h0456, 1'b0, 1'b0);
        proc_u.rd(BASE ^ 16'h0800, 1'b1, rv);
        chk("answers", 16'(n_ans - n0), 16'h0000);
        chk("chan0", {4'h0, chans[0]}, 16'h0800);
    endtask

    task automatic t_rst;
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        all_zero();
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        sw = SW;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        all_zero();
        t_word();
        t_byte();
        t_refuse();
        t_rst();
        complete_run();
    end
endmodule
`default_nettype wire
